/* File: poc_regs.svh */
// Purpose: register offsets, field positions and reset values
// Assumes: AHB-Lite, one 32-bit aligned word per register
// Notes: 16-bit registers sit in bits 15:0, bits above read zero
`ifndef POC_REGS_SVH
`define POC_REGS_SVH
`define POC_NOISE_CANCEL_CONFIG 12'h000
`define POC_FINAL_OUTPUT_OFFSET 12'h004
`define POC_FINAL_OUTPUT_GAIN 12'h008
`define POC_OUTPUT_CLAMP_FLOOR 12'h00c
`define POC_OUTPUT_CLAMP_CEILING 12'h010
`define POC_SUPPLY_LIMIT_LEVELS 12'h014
`define POC_FRONTEND_CONFIG 12'h018
`define POC_DATAPATH_CONFIG 12'h01c
`define POC_AMP_LOW_LIMIT 12'h020
`define POC_AMP_HIGH_LIMIT 12'h024
`define POC_IRQ_STATUS 12'h028
`define POC_IRQ_MASK 12'h02c
`define POC_OUTPUT_VALUE 12'h030
`define POC_NC_THRESH_MSB 15
`define POC_NC_THRESH_LSB 8
`define POC_NC_FACTOR_MSB 7
`define POC_NC_FACTOR_LSB 0
`define POC_FE_LOCK_BIT 15
`define POC_FE_MODULO_MSB 7
`define POC_FE_MODULO_LSB 6
`define POC_FE_RATE_MSB 5
`define POC_FE_RATE_LSB 4
`define POC_FE_SETUP_MSB 3
`define POC_FE_SETUP_LSB 0
`define POC_DP_NMULT_MSB 7
`define POC_DP_NMULT_LSB 5
`define POC_DP_SLOPE_MSB 4
`define POC_DP_SLOPE_LSB 1
`define POC_DP_VARSP_BIT 0
`define POC_RESET_ZERO 16'h0000
`define POC_RESET_GAIN 16'h4000
`define POC_RESET_CEILING 16'h7fff
`define POC_RESET_AMP_HIGH 16'h7fff
`define POC_SETUP_MAX 4'h7
`define POC_GAIN_SHIFT 14
`endif

/* File: poc_pkg.sv */
// Purpose: shared types of the output conditioning block
// Assumes: nothing beyond the register header
// Notes: bus transfer types follow AHB-Lite encodings
package poc_pkg;
    typedef enum logic [1:0] {
        POC_IDLE = 2'b00,
        POC_BUSY = 2'b01,
        POC_NONSEQ = 2'b10,
        POC_SEQ = 2'b11
    } poc_htrans_t;
    typedef enum logic [1:0] {
        POC_MOD_360 = 2'b00,
        POC_MOD_90 = 2'b01,
        POC_MOD_120 = 2'b10,
        POC_MOD_180 = 2'b11
    } poc_modulo_t;
    typedef enum logic [1:0] {
        POC_FS_IDLE = 2'b00,
        POC_FS_FILTER = 2'b01,
        POC_FS_SCALE = 2'b11
    } poc_fstate_t;
endpackage

/* File: poc_noise_filter.sv */
// Purpose: threshold-gated first-order iir smoothing of the angle
// Assumes: one sample per sample_valid_i pulse, same clock
// Notes: output follows the input in the same cycle, so no added delay
`timescale 1ns/100ps
`default_nettype none
module poc_noise_filter (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic sample_valid_i,
    input wire logic [15:0] sample_i,
    input wire logic [7:0] threshold_i,
    input wire logic [7:0] factor_i,
    output logic [15:0] filtered_o
);
    logic [23:0] acc;
    logic [23:0] next_acc;
    logic signed [16:0] diff;
    logic small_step;
    logic enabled;
    always_comb begin
        // enable flag clears only when both fields are zero; a zero threshold alone already passes every sample unfiltered
        enabled = (threshold_i != 8'h00) || (factor_i != 8'h00);
        diff = $signed({sample_i[15], sample_i}) -
            $signed({acc[23], acc[23:8]});
        small_step = (diff < $signed({9'h000, threshold_i})) &&
            (diff > -$signed({9'h000, threshold_i}));
        next_acc = acc;
        if (sample_valid_i) begin
            if (enabled && small_step) begin
                // factor sets the step fraction, lower means lower cutoff
                next_acc = acc + 24'(($signed(diff) *
                    $signed({1'b0, factor_i})) >>> 0);
            end else begin
                next_acc = {sample_i, 8'h00};
            end
        end
        // fractional bits keep full resolution in the accumulator
        filtered_o = (sample_valid_i && !(enabled && small_step)) ?
            sample_i : next_acc[23:8];
    end
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            acc <= 24'h000000;
        end else begin
            acc <= next_acc;
        end
    end
endmodule
`default_nettype wire

/* File: poc_top.sv */
// Purpose: output conditioning back end with its configuration registers
// Assumes: AHB-Lite single word transfers, angle_valid_i one-cycle pulse
// Notes: zero wait states; unmapped addresses read zero
// What this block does
// - extra iir smoothing only while sample change stays below threshold
// - filter factor from low byte, threshold from high byte, both 8 bits
// - large changes pass unfiltered; no resolution loss, no extra latency
// - filter disabled when both fields are zero
// - final 16-bit signed offset added to output
// - final 16-bit signed gain multiplies output; negative gain inverts
// - output clamped between signed floor and ceiling levels
// - supply register holds overvoltage high byte, undervoltage low byte
// - frontend bit 15 is the customer lock
// - frontend bits 7:6 select 360, 90, 120 or 180 degree modulo
// - frontend bits 5:4 select 2, 4, 8 or 16 ksps sample rate
// - frontend bits 3:0 select setup; only codes 0 to 7 valid
// - setpoint input scaled by gain coefficient times two to nmult
// - segment slope is coefficient times two to the 4-bit exponent
// - datapath bit 0 selects fixed or variable setpoint positions
// - amplitude outside low or high limit flags an error
`timescale 1ns/100ps
`default_nettype none
`include "poc_regs.svh"
module poc_top (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic angle_valid_i,
    input wire logic [15:0] angle_i,
    input wire logic [15:0] amplitude_i,
    input wire logic [15:0] breakpoint_input_gain_i,
    input wire logic [15:0] breakpoint_stage_input_i,
    input wire logic [15:0] segment_slope_coef_i,
    output logic [15:0] position_o,
    output logic position_valid_o,
    output logic [31:0] breakpoint_scaled_o,
    output logic [31:0] segment_slope_o,
    output logic variable_setpoints_o,
    output logic [1:0] modulo_sel_o,
    output logic [4:0] sample_rate_ksps_o,
    output logic [3:0] measurement_setup_o,
    output logic customer_lock_o,
    output logic [7:0] overvoltage_threshold_o,
    output logic [7:0] undervoltage_threshold_o,
    output logic amplitude_error_o,
    output logic irq_o
);
    localparam int NREG = 13;
    logic [15:0] regs [NREG];
    logic [15:0] next_regs [NREG];
    logic [1:0] irq_status;
    logic [1:0] next_irq_status;
    logic wr_pend;
    logic next_wr_pend;
    logic [3:0] wr_idx;
    logic [3:0] next_wr_idx;
    logic [31:0] next_hrdata;
    logic [15:0] filtered;
    logic [15:0] modded;
    logic signed [33:0] scaled;
    logic signed [16:0] clamped;
    logic [15:0] next_position;
    logic next_position_valid;
    logic next_amp_err;
    logic [31:0] next_bp;
    logic [31:0] next_slope;
    logic setup_err;
    logic addr_ok;
    logic next_varsp;
    logic [1:0] next_modulo;
    logic [4:0] next_rate;
    logic [3:0] next_setup;
    logic next_lock;
    logic [7:0] next_ov;
    logic [7:0] next_uv;
    logic next_irq;

    function automatic logic [3:0] poc_index(input logic [31:0] a);
        poc_index = a[5:2];
    endfunction

    // sample stage shares the clock, so no resynchronising
    poc_noise_filter u_filter (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .sample_valid_i(angle_valid_i),
        .sample_i(angle_i),
        .threshold_i(regs[0][`POC_NC_THRESH_MSB:`POC_NC_THRESH_LSB]),
        .factor_i(regs[0][`POC_NC_FACTOR_MSB:`POC_NC_FACTOR_LSB]),
        .filtered_o(filtered)
    );

    // bus slave
    always_comb begin
        addr_ok = (haddr_i[11:0] <= `POC_OUTPUT_VALUE) &&
            (haddr_i[31:12] == 20'h00000);
        next_wr_pend = hsel_i && hready_i && hwrite_i &&
            (htrans_i == 2'(poc_pkg::POC_NONSEQ)) && addr_ok;
        next_wr_idx = poc_index(haddr_i);
        next_hrdata = 32'h00000000;
        if (hsel_i && hready_i && !hwrite_i && addr_ok &&
            htrans_i == 2'(poc_pkg::POC_NONSEQ)) begin
            if (poc_index(haddr_i) == 4'ha) begin
                next_hrdata = {30'h00000000, irq_status};
            end else if (poc_index(haddr_i) == 4'hc) begin
                next_hrdata = {16'h0000, position_o};
            end else begin
                next_hrdata = {16'h0000, regs[poc_index(haddr_i)]};
            end
        end
        for (int i = 0; i < NREG; i++) begin
            next_regs[i] = regs[i];
        end
        // lock freezes every register except write-one irq status clears; the lock bit stays set
        if (wr_pend && wr_idx != 4'ha && wr_idx != 4'hc &&
            !regs[6][`POC_FE_LOCK_BIT]) begin
            next_regs[wr_idx] = hwdata_i[15:0];
            if (wr_idx == 4'h6) begin
                next_regs[6][14:8] = 7'h00;
            end
            if (wr_idx == 4'h7) begin
                next_regs[7][15:8] = 8'h00;
            end
        end
    end

    // datapath: filter, modulo, offset and gain, then clamp
    always_comb begin
        unique case (poc_pkg::poc_modulo_t'(regs[6][7:6]))
            poc_pkg::POC_MOD_360: modded = filtered;
            poc_pkg::POC_MOD_90: modded = {filtered[13:0], 2'b00};
            poc_pkg::POC_MOD_120:
                modded = 16'((32'(filtered) * 32'd3) % 32'h10000);
            poc_pkg::POC_MOD_180: modded = {filtered[14:0], 1'b0};
        endcase
        // offset first, then gain in q2.14 so 16'h4000 is unity
        scaled = (34'($signed({modded[15], modded})) +
            34'($signed(regs[1]))) * 34'($signed(regs[2]));
        scaled = scaled >>> `POC_GAIN_SHIFT;
        if (scaled < 34'($signed(regs[3]))) begin
            clamped = 17'($signed(regs[3]));
        end else if (scaled > 34'($signed(regs[4]))) begin
            clamped = 17'($signed(regs[4]));
        end else begin
            clamped = scaled[16:0];
        end
        next_position = angle_valid_i ? clamped[15:0] : position_o;
        next_position_valid = angle_valid_i;
        next_amp_err = ($signed(amplitude_i) < $signed(regs[8])) ||
            ($signed(amplitude_i) > $signed(regs[9]));
        setup_err = regs[6][3:0] > `POC_SETUP_MAX;
        next_bp = 32'($signed(breakpoint_stage_input_i) *
            $signed(breakpoint_input_gain_i)) <<
            regs[7][`POC_DP_NMULT_MSB:`POC_DP_NMULT_LSB];
        next_slope = 32'($signed(segment_slope_coef_i)) <<
            regs[7][`POC_DP_SLOPE_MSB:`POC_DP_SLOPE_LSB];
        // hardware set wins over a write-one clear
        next_irq_status = irq_status;
        if (wr_pend && wr_idx == 4'ha) begin
            next_irq_status = irq_status & ~hwdata_i[1:0];
        end
        next_irq_status = next_irq_status | {setup_err, next_amp_err};
    end

    // configuration outputs lag their register by one cycle
    always_comb begin
        next_varsp = regs[7][`POC_DP_VARSP_BIT];
        next_modulo = regs[6][`POC_FE_MODULO_MSB:`POC_FE_MODULO_LSB];
        // rate code n means 2 shl n ksps; five bits so 16 fits
        next_rate = 5'h02 <<
            regs[6][`POC_FE_RATE_MSB:`POC_FE_RATE_LSB];
        next_setup = regs[6][`POC_FE_SETUP_MSB:`POC_FE_SETUP_LSB];
        next_lock = regs[6][`POC_FE_LOCK_BIT];
        next_ov = regs[5][15:8];
        next_uv = regs[5][7:0];
        next_irq = |(next_irq_status & regs[11][1:0]);
    end

    // register file and bus state
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            regs[0] <= `POC_RESET_ZERO;
            regs[1] <= `POC_RESET_ZERO;
            regs[2] <= `POC_RESET_GAIN;
            regs[3] <= `POC_RESET_ZERO;
            regs[4] <= `POC_RESET_CEILING;
            regs[5] <= `POC_RESET_ZERO;
            regs[6] <= `POC_RESET_ZERO;
            regs[7] <= `POC_RESET_ZERO;
            regs[8] <= `POC_RESET_ZERO;
            regs[9] <= `POC_RESET_AMP_HIGH;
            regs[10] <= `POC_RESET_ZERO;
            regs[11] <= `POC_RESET_ZERO;
            regs[12] <= `POC_RESET_ZERO;
            irq_status <= 2'b00;
            wr_pend <= 1'b0;
            wr_idx <= 4'h0;
            hrdata_o <= 32'h00000000;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else begin
            for (int i = 0; i < NREG; i++) begin
                regs[i] <= next_regs[i];
            end
            irq_status <= next_irq_status;
            wr_pend <= next_wr_pend;
            wr_idx <= next_wr_idx;
            hrdata_o <= next_hrdata;
            // zero wait states, so the slave never stretches a phase
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
    end

    // datapath results
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            position_o <= 16'h0000;
            position_valid_o <= 1'b0;
            breakpoint_scaled_o <= 32'h00000000;
            segment_slope_o <= 32'h00000000;
            amplitude_error_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            position_o <= next_position;
            position_valid_o <= next_position_valid;
            breakpoint_scaled_o <= next_bp;
            segment_slope_o <= next_slope;
            amplitude_error_o <= next_amp_err;
            irq_o <= next_irq;
        end
    end

    // configuration outputs
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            variable_setpoints_o <= 1'b0;
            modulo_sel_o <= 2'b00;
            sample_rate_ksps_o <= 5'h02;
            measurement_setup_o <= 4'h0;
            customer_lock_o <= 1'b0;
            overvoltage_threshold_o <= 8'h00;
            undervoltage_threshold_o <= 8'h00;
        end else begin
            variable_setpoints_o <= next_varsp;
            modulo_sel_o <= next_modulo;
            sample_rate_ksps_o <= next_rate;
            measurement_setup_o <= next_setup;
            customer_lock_o <= next_lock;
            overvoltage_threshold_o <= next_ov;
            undervoltage_threshold_o <= next_uv;
        end
    end
endmodule
`default_nettype wire

/* File: poc_top_sva.sv */
// Purpose: port-level checks of the output conditioning block
// Assumes: one clock, asynchronous active-low reset
// Notes: config outputs may only move shortly after a taken bus write
`timescale 1ns/100ps
`default_nettype none
module poc_top_sva (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic hsel_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic angle_valid_i,
    input wire logic [15:0] amplitude_i,
    input wire logic [15:0] position_o,
    input wire logic position_valid_o,
    input wire logic variable_setpoints_o,
    input wire logic [1:0] modulo_sel_o,
    input wire logic [4:0] sample_rate_ksps_o,
    input wire logic [3:0] measurement_setup_o,
    input wire logic customer_lock_o,
    input wire logic [7:0] overvoltage_threshold_o,
    input wire logic [7:0] undervoltage_threshold_o,
    input wire logic amplitude_error_o
);
    logic [2:0] since_wr;
    logic [2:0] next_since_wr;
    logic [10:0] fe;
    logic [28:0] cfg;
    assign fe = {modulo_sel_o, sample_rate_ksps_o, measurement_setup_o};
    assign cfg = {fe, customer_lock_o, variable_setpoints_o,
        overvoltage_threshold_o, undervoltage_threshold_o};
    // saturating age of the last taken write
    always_comb begin
        next_since_wr = (since_wr == 3'h7) ? since_wr : since_wr + 3'h1;
        if (hsel_i && hready_i && htrans_i == 2'h2 && hwrite_i) begin
            next_since_wr = 3'h0;
        end
    end
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            since_wr <= 3'h7;
        end else begin
            since_wr <= next_since_wr;
        end
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    a_pos_follows: assert property (angle_valid_i |=> position_valid_o)
        else $error("no position one cycle after sample");
    a_pos_cause: assert property (position_valid_o |-> $past(angle_valid_i))
        else $error("position valid without a sample");
    a_pos_held: assert property (!$past(angle_valid_i) |-> $stable(position_o))
        else $error("position moved without a sample");
    a_lock_holds: assert property (customer_lock_o |=>
        customer_lock_o && $stable(fe))
        else $error("locked configuration changed");
    a_cfg_by_write: assert property ($changed(cfg) |-> since_wr <= 3'h3)
        else $error("configuration changed without a write");
    a_amp_cause: assert property ($changed(amplitude_error_o) |->
        $past(amplitude_i) != $past(amplitude_i, 2) || since_wr <= 3'h3)
        else $error("amplitude flag moved without cause");
    a_bus_okay: assert property (hreadyout_o && !hresp_o)
        else $error("slave not ready or not okay");
    a_rdata_idle: assert property (!$past(hsel_i && hready_i &&
        htrans_i == 2'h2 && !hwrite_i) |-> hrdata_o == 32'h0)
        else $error("read data outside a read data phase");
endmodule
`default_nettype wire

/* File: position_output_conditioning_bench.sv */
// Purpose: self-checking bench of the output conditioning block
// Assumes: zero wait state slave, hready looped from hreadyout
// Notes: every transfer starts at least one idle cycle after the previous one
`timescale 1ns/100ps
`default_nettype none
`include "poc_regs.svh"
module position_output_conditioning_bench;
    logic sys_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic hsel_i = 1'b0;
    logic hwrite_i = 1'b0;
    logic angle_valid_i = 1'b0;
    logic [1:0] htrans_i = 2'h0;
    logic [2:0] hsize_i = 3'h2;
    logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, rd;
    logic [15:0] angle_i = 16'h0, amplitude_i = 16'h0;
    logic [15:0] breakpoint_input_gain_i = 16'h2;
    logic [15:0] breakpoint_stage_input_i = 16'h3;
    logic [15:0] segment_slope_coef_i = 16'hfffe;
    logic [31:0] hrdata_o, breakpoint_scaled_o, segment_slope_o;
    logic hreadyout_o, hresp_o, position_valid_o, variable_setpoints_o;
    logic customer_lock_o, amplitude_error_o, irq_o;
    logic [15:0] position_o;
    logic [1:0] modulo_sel_o;
    logic [4:0] sample_rate_ksps_o;
    logic [3:0] measurement_setup_o;
    logic [7:0] overvoltage_threshold_o, undervoltage_threshold_o;
    logic [15:0] mexp [4] = '{16'h1234, 16'h48d0, 16'h369c, 16'h2468};
    int bad_count = 0;
    int cmp_count = 0;
    always #10 sys_clk_i = ~sys_clk_i;
    poc_top DUT (.*, .hready_i(hreadyout_o));
    task chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task phase;
        logic r;
        do begin
            @(negedge sys_clk_i);
            r = hreadyout_o;
            rd = hrdata_o;
            @(posedge sys_clk_i);
        end while (r !== 1'b1);
    endtask
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        hsel_i <= 1'b1;
        haddr_i <= {20'h0, a};
        htrans_i <= 2'h2;
        hwrite_i <= w;
        phase;
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        phase;
    endtask
    task rchk(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task nap;
        repeat (2) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
    endtask
    task send(input logic [15:0] a, input logic [15:0] e);
        @(posedge sys_clk_i);
        angle_valid_i <= 1'b1;
        angle_i <= a;
        @(posedge sys_clk_i);
        angle_valid_i <= 1'b0;
        @(negedge sys_clk_i);
        chk(position_valid_o, 1'b1);
        chk(position_o, e);
    endtask
    task t_regs;
        rchk(`POC_FINAL_OUTPUT_GAIN, 32'h4000);
        rchk(`POC_OUTPUT_CLAMP_CEILING, 32'h7fff);
        rchk(`POC_NOISE_CANCEL_CONFIG, 32'h0);
        xfer(1'b1, `POC_FINAL_OUTPUT_OFFSET, 32'h12340100);
        rchk(`POC_FINAL_OUTPUT_OFFSET, 32'h0100);
        rchk(12'h040, 32'h0);
    endtask
    task t_scale;
        send(16'h2000, 16'h2100);
        xfer(1'b1, `POC_FINAL_OUTPUT_GAIN, 32'hc000);
        send(16'h2000, 16'h0000);
        xfer(1'b1, `POC_FINAL_OUTPUT_GAIN, 32'h4000);
        xfer(1'b1, `POC_OUTPUT_CLAMP_CEILING, 32'h0800);
        send(16'h2000, 16'h0800);
        xfer(1'b1, `POC_OUTPUT_CLAMP_CEILING, 32'h7fff);
        xfer(1'b1, `POC_FINAL_OUTPUT_OFFSET, 32'h0);
    endtask
    task t_filter;
        send(16'h2000, 16'h2000);
        xfer(1'b1, `POC_NOISE_CANCEL_CONFIG, 32'h4080);
        send(16'h2020, 16'h2010);
        send(16'h2200, 16'h2200);
        xfer(1'b1, `POC_NOISE_CANCEL_CONFIG, 32'h0);
        send(16'h2210, 16'h2210);
    endtask
    task t_cfg;
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, `POC_FRONTEND_CONFIG, {24'h0, i[1:0], i[1:0], 4'h7});
            nap;
            chk(modulo_sel_o, i[1:0]);
            chk(measurement_setup_o, 4'h7);
            chk(sample_rate_ksps_o, 32'h2 << i);
            send(16'h1234, mexp[i]);
        end
        xfer(1'b1, `POC_SUPPLY_LIMIT_LEVELS, 32'ha55a);
        xfer(1'b1, `POC_DATAPATH_CONFIG, 32'h00ab);
        nap;
        chk(overvoltage_threshold_o, 8'ha5);
        chk(undervoltage_threshold_o, 8'h5a);
        chk(variable_setpoints_o, 1'b1);
        chk(breakpoint_scaled_o, 32'hc0);
        chk(segment_slope_o, 32'hffffffc0);
        xfer(1'b1, `POC_DATAPATH_CONFIG, 32'h00aa);
        nap;
        chk(variable_setpoints_o, 1'b0);
    endtask
    task t_irq;
        @(posedge sys_clk_i);
        amplitude_i <= 16'h8000;
        nap;
        chk(amplitude_error_o, 1'b1);
        chk(irq_o, 1'b0);
        xfer(1'b1, `POC_IRQ_MASK, 32'h1);
        @(posedge sys_clk_i);
        amplitude_i <= 16'h0100;
        nap;
        chk(amplitude_error_o, 1'b0);
        chk(irq_o, 1'b1);
        xfer(1'b1, `POC_IRQ_STATUS, 32'h1);
        nap;
        chk(irq_o, 1'b0);
    endtask
    task t_lock;
        xfer(1'b1, `POC_FRONTEND_CONFIG, 32'h8000);
        xfer(1'b1, `POC_FRONTEND_CONFIG, 32'h00c0);
        nap;
        chk(customer_lock_o, 1'b1);
        chk(modulo_sel_o, 2'h0);
    endtask
    task report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        t_regs;
        t_scale;
        t_filter;
        t_cfg;
        t_irq;
        t_lock;
        report_and_stop;
    end
    // whole run needs well under a thousand cycles
    initial begin
        #100000;
        bad_count++;
        report_and_stop;
    end
endmodule
bind poc_top poc_top_sva u_sva (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .angle_valid_i(angle_valid_i),
    .amplitude_i(amplitude_i), .position_o(position_o),
    .position_valid_o(position_valid_o),
    .variable_setpoints_o(variable_setpoints_o),
    .modulo_sel_o(modulo_sel_o), .sample_rate_ksps_o(sample_rate_ksps_o),
    .measurement_setup_o(measurement_setup_o),
    .customer_lock_o(customer_lock_o),
    .overvoltage_threshold_o(overvoltage_threshold_o),
    .undervoltage_threshold_o(undervoltage_threshold_o),
    .amplitude_error_o(amplitude_error_o));
`default_nettype wire
